// [hw/legacy_port_map.svh]
`ifndef LEGACY_PORT_MAP_SVH
`define LEGACY_PORT_MAP_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define IDX_ECP_SW_IND     8'h22
`define IDX_PAR_BASE       8'h23
`define IDX_SER1_BASE      8'h24
`define IDX_SER2_BASE      8'h25
`define IDX_PAR_DMA        8'h26
`define IDX_PAR_IRQ        8'h27

// ----------------------------------------------------------------------
// Register bus offsets
// ----------------------------------------------------------------------
`define OFF_INDEX          2'h0
`define OFF_DATA           2'h1
`define OFF_CONTROL        2'h2

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ECP_SW_MASK        8'h3F
`define SER_BASE_MASK      8'hFE
`define CTRL_CFG_BIT       0
`define CTRL_EPP_BIT       1
`define CTRL_ECP_BIT       2
`define CTRL_MASK          8'h07
`define REG_RESET          8'h00
`define DMA_CODE_NONE      4'hF
`define IRQ_CODE_NONE      4'h0

`endif

// [hw/legacy_port_pkg.sv]
package legacy_port_pkg;

    // Parallel port operating modes
    typedef enum logic [1:0] {
        PMODE_COMPAT = 2'h0,
        PMODE_EPP    = 2'h1,
        PMODE_ECP    = 2'h2
    } par_mode_t;

endpackage : legacy_port_pkg

// [hw/legacy_port_resource_map.sv]
// Summary of operation
// - ECP indicator stores DMA/IRQ fields, software only
// - Reserved bits read back as zero
// - Access only in config state via index
// - Non-EPP parallel decode ignores A[1:0]
// - EPP parallel decode ignores A[2:0]
// - Top base bits zero disable decoding
// - A[15:10] zero, except A10 in ECP
// - Parallel base bits 0..7 compare A[9:2]
// - Serial one base bits 1..7 compare A[9:3]
// - Serial one needs A[15:10] zero, match
// - Serial two base bits 1..7 compare A[9:3]
// - Serial two needs A[15:10] zero, match
// - DMA code 1..3 selects channel, F none
// - Unselected DMA request lines tristated
// - IRQ code 1..15 selects line, 0 none
// - Unselected IRQ lines tristated
// - All registers reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "legacy_port_map.svh"

module legacy_port_resource_map (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Host address (pins)
    input  wire logic [15:0] host_addr,
    // Port selects
    output logic             par_sel,
    output logic             par_upper_sel,
    output logic             ser1_sel,
    output logic             ser2_sel,
    // Parallel port requests
    input  wire logic        par_dma_req,
    input  wire logic        par_irq,
    // DMA request pins, channels 1..3
    output logic      [3:1]  dma_request_out,
    output logic      [3:1]  dma_request_oe,
    // IRQ pins, lines 1..15
    output logic      [15:1] irq_out,
    output logic      [15:1] irq_oe
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic base_enabled(input logic [7:0] base);
        base_enabled = base[7] | base[6];
    endfunction : base_enabled

    // Both serial decoders compare A[9:3] against base bits 7:1
    function automatic logic ser_match(input logic [15:0] a,
                                       input logic [7:0]  base);
        ser_match = (a[9:3] == base[7:1]);
    endfunction : ser_match

    // Read data is zero outside the cycle after a read strobe
    function automatic logic [7:0] reg_req_data(input logic       rd,
                                                input logic [7:0] d);
        reg_req_data = rd ? d : 8'h00;
    endfunction : reg_req_data

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  index_q;
    logic [7:0]  control_q;
    logic [7:0]  ecp_sw_q;
    logic [7:0]  par_base_q;
    logic [7:0]  ser1_base_q;
    logic [7:0]  ser2_base_q;
    logic [7:0]  par_dma_q;
    logic [7:0]  par_irq_q;
    logic [15:0] addr_s1_q;
    logic [15:0] addr_s2_q;
    logic [1:0]  req_s1_q;
    logic [1:0]  req_s2_q;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire        cfg_mode  = control_q[`CTRL_CFG_BIT];
    wire        epp_en    = control_q[`CTRL_EPP_BIT];
    wire        ecp_en    = control_q[`CTRL_ECP_BIT];
    wire        wr_index  = reg_wr && (reg_addr == `OFF_INDEX);
    wire        wr_ctrl   = reg_wr && (reg_addr == `OFF_CONTROL);
    // Data window is dead outside configuration state
    wire        wr_data   = reg_wr && (reg_addr == `OFF_DATA)
                            && cfg_mode;
    wire        wr_ecp    = wr_data && (index_q == `IDX_ECP_SW_IND);
    wire        wr_pbase  = wr_data && (index_q == `IDX_PAR_BASE);
    wire        wr_s1base = wr_data && (index_q == `IDX_SER1_BASE);
    wire        wr_s2base = wr_data && (index_q == `IDX_SER2_BASE);
    wire        wr_pdma   = wr_data && (index_q == `IDX_PAR_DMA);
    wire        wr_pirq   = wr_data && (index_q == `IDX_PAR_IRQ);

    logic [7:0] data_sel;
    always_comb begin
        unique case (index_q)
            `IDX_ECP_SW_IND: data_sel = ecp_sw_q;
            `IDX_PAR_BASE:   data_sel = par_base_q;
            `IDX_SER1_BASE:  data_sel = ser1_base_q;
            `IDX_SER2_BASE:  data_sel = ser2_base_q;
            `IDX_PAR_DMA:    data_sel = par_dma_q;
            `IDX_PAR_IRQ:    data_sel = par_irq_q;
            default:         data_sel = 8'h00;
        endcase
    end

    wire [7:0] data_rd = cfg_mode ? data_sel : 8'h00;

    logic [7:0] rdata_d;
    always_comb begin
        unique case (reg_addr)
            `OFF_INDEX:   rdata_d = index_q;
            `OFF_DATA:    rdata_d = data_rd;
            `OFF_CONTROL: rdata_d = control_q;
            default:      rdata_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Index and control storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            index_q <= `REG_RESET;
        end else if (wr_index) begin
            index_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            control_q <= `REG_RESET;
        end else if (wr_ctrl) begin
            control_q <= reg_wdata & `CTRL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Resource register storage
    // ------------------------------------------------------------------
    // Software-only value, drives no routing
    always_ff @(posedge clk) begin
        if (rst) begin
            ecp_sw_q <= `REG_RESET;
        end else if (wr_ecp) begin
            ecp_sw_q <= reg_wdata & `ECP_SW_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            par_base_q <= `REG_RESET;
        end else if (wr_pbase) begin
            par_base_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ser1_base_q <= `REG_RESET;
        end else if (wr_s1base) begin
            ser1_base_q <= reg_wdata & `SER_BASE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ser2_base_q <= `REG_RESET;
        end else if (wr_s2base) begin
            ser2_base_q <= reg_wdata & `SER_BASE_MASK;
        end
    end

    // Upper nibble kept as written; software owns its value
    always_ff @(posedge clk) begin
        if (rst) begin
            par_dma_q <= `REG_RESET;
        end else if (wr_pdma) begin
            par_dma_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            par_irq_q <= `REG_RESET;
        end else if (wr_pirq) begin
            par_irq_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_req_data(reg_rd, rdata_d);
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Only the second stage is read by the decoders
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_s1_q <= 16'h0000;
        end else begin
            addr_s1_q <= host_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_s2_q <= 16'h0000;
        end else begin
            addr_s2_q <= addr_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_s1_q <= 2'h0;
        end else begin
            req_s1_q <= {par_irq, par_dma_req};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_s2_q <= 2'h0;
        end else begin
            req_s2_q <= req_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Address decoders
    // ------------------------------------------------------------------
    legacy_port_pkg::par_mode_t pmode;
    assign pmode = ecp_en ? legacy_port_pkg::PMODE_ECP
                 : (epp_en ? legacy_port_pkg::PMODE_EPP
                           : legacy_port_pkg::PMODE_COMPAT);

    wire       hi_zero  = (addr_s2_q[15:11] == 5'h00);
    wire       a10      = addr_s2_q[10];
    // ECP lets A10 pick the upper register group
    wire       par_hi_ok = hi_zero && ((pmode == legacy_port_pkg::PMODE_ECP)
                                       || !a10);
    // EPP frees A2 for its own register block
    wire       par_match = (pmode == legacy_port_pkg::PMODE_EPP)
        ? (addr_s2_q[9:3] == par_base_q[7:1])
        : (addr_s2_q[9:2] == par_base_q);
    wire       par_hit  = base_enabled(par_base_q) && par_hi_ok
                          && par_match;
    wire       s1_hit   = base_enabled(ser1_base_q) && hi_zero && !a10
                          && ser_match(addr_s2_q, ser1_base_q);
    wire       s2_hit   = base_enabled(ser2_base_q) && hi_zero && !a10
                          && ser_match(addr_s2_q, ser2_base_q);

    // ------------------------------------------------------------------
    // DMA and IRQ routing
    // ------------------------------------------------------------------
    wire [3:0] dma_code = par_dma_q[3:0];
    wire [3:0] irq_code = par_irq_q[3:0];
    logic [3:1] dma_oe_d;
    logic [15:1] irq_oe_d;
    always_comb begin
        dma_oe_d = 3'h0;
        irq_oe_d = 15'h0000;
        // Reserved codes and NONE leave every channel released
        for (int i = 1; i <= 3; i++) begin
            if (dma_code == 4'(i))
                dma_oe_d[i] = 1'b1;
        end
        for (int j = 1; j <= 15; j++) begin
            if (irq_code == 4'(j))
                irq_oe_d[j] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Port select outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            par_sel <= 1'b0;
        end else begin
            par_sel <= par_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            par_upper_sel <= 1'b0;
        end else begin
            par_upper_sel <= par_hit && a10;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ser1_sel <= 1'b0;
        end else begin
            ser1_sel <= s1_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ser2_sel <= 1'b0;
        end else begin
            ser2_sel <= s2_hit;
        end
    end

    // ------------------------------------------------------------------
    // DMA and IRQ pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_request_oe <= 3'h0;
        end else begin
            dma_request_oe <= dma_oe_d;
        end
    end

    // Released lines also drive low, so nothing floats inside the chip
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_request_out <= 3'h0;
        end else begin
            dma_request_out <= dma_oe_d & {3{req_s2_q[0]}};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_oe <= 15'h0000;
        end else begin
            irq_oe <= irq_oe_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_out <= 15'h0000;
        end else begin
            irq_out <= irq_oe_d & {15{req_s2_q[1]}};
        end
    end

endmodule : legacy_port_resource_map
`default_nettype wire

// [verif/legacy_port_resource_map_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module legacy_port_resource_map_monitor (
    // Clock, reset and register port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [1:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Decode and routing
    input wire logic [15:0] host_addr,
    input wire logic        par_sel,
    input wire logic        par_upper_sel,
    input wire logic        ser1_sel,
    input wire logic        ser2_sel,
    input wire logic        par_dma_req,
    input wire logic        par_irq,
    input wire logic [3:1]  dma_request_out,
    input wire logic [3:1]  dma_request_oe,
    input wire logic [15:1] irq_out,
    input wire logic [15:1] irq_oe
);
    // ------
    // Checks
    // ------
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Shadow of the index, so reads can be tied to the register read
    logic [7:0] idx_q;
    logic       data_rd;
    assign data_rd = reg_rd && reg_addr == 2'h1;
    always_ff @(posedge clk) begin
        if (rst) idx_q <= 8'h00;
        else if (reg_wr && reg_addr == 2'h0) idx_q <= reg_wdata;
    end
    AST_RDATA_IDLE: assert property (
        reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("rdata without read");
    AST_UNMAPPED: assert property (
        $past(reg_rd && reg_addr == 2'h3) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ECP_RSVD: assert property (
        $past(data_rd && idx_q == 8'h22) |-> reg_rdata[7:6] == 2'b00)
        else $error("indicator reserved bits set");
    AST_SER_RSVD: assert property (
        $past(data_rd && idx_q[7:1] == 7'h12) |-> !reg_rdata[0])
        else $error("serial base bit 0 set");
    AST_RESET_OUT: assert property (
        $fell(rst) |-> !(par_sel || par_upper_sel || ser1_sel || ser2_sel)
        && dma_request_oe == 3'h0 && irq_oe == 15'h0)
        else $error("outputs active after reset");
    AST_DMA_ONEHOT: assert property (
        $onehot0(dma_request_oe)) else $error("several dma lines driven");
    AST_IRQ_ONEHOT: assert property (
        $onehot0(irq_oe)) else $error("several irq lines driven");
    AST_PAR_HIGH: assert property (
        (par_sel || par_upper_sel) |-> $past(host_addr[15:11], 3) == 5'h00)
        else $error("parallel hit with high address");
    AST_SER_HIGH: assert property (
        (ser1_sel || ser2_sel) |-> $past(host_addr[15:10], 3) == 6'h00)
        else $error("serial hit with high address");
    AST_IRQ_OUT: assert property (
        irq_oe != 15'h0 |-> (irq_out & irq_oe)
        == (irq_oe & {15{$past(par_irq, 3)}})) else $error("irq level wrong");
    cover property (par_sel);
    cover property (ser2_sel);
    cover property (irq_oe != 15'h0);
endmodule : legacy_port_resource_map_monitor
bind legacy_port_resource_map legacy_port_resource_map_monitor u_mon (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_addr, .par_sel, .par_upper_sel, .ser1_sel, .ser2_sel,
    .par_dma_req, .par_irq, .dma_request_out, .dma_request_oe,
    .irq_out, .irq_oe);
`default_nettype wire

// [verif/legacy_port_resource_map_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module legacy_port_resource_map_tb;
    logic        clk, rst, reg_wr, reg_rd, par_dma_req, par_irq;
    logic        par_sel, par_upper_sel, ser1_sel, ser2_sel;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d, e8;
    logic [15:0] host_addr;
    logic [3:1]  dma_request_out, dma_request_oe, e3;
    logic [15:1] irq_out, irq_oe, e15;
    int          num_errors, n_tests, cycles, i;
    legacy_port_resource_map u_legacy_port_resource_map (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .host_addr, .par_sel, .par_upper_sel, .ser1_sel, .ser2_sel,
        .par_dma_req, .par_irq, .dma_request_out, .dma_request_oe,
        .irq_out, .irq_oe);
    // -----
    // Tasks
    // -----
    task check(input string nm, input logic [14:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task set(input logic [7:0] idx, v);
        wr(2'h0, idx);
        wr(2'h1, v);
    endtask : set
    task get(input logic [7:0] idx, output logic [7:0] v);
        wr(2'h0, idx);
        rd(2'h1, v);
    endtask : get
    // Decode goes through a two-flop sync, so allow four edges
    task hit(input logic [15:0] a);
        @(posedge clk);
        host_addr <= a;
        repeat (4) @(posedge clk);
        #1;
    endtask : hit
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // --------
    // Sequence
    // --------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        {rst, reg_wr, reg_rd, par_dma_req, par_irq} = 5'b10000;
        {reg_addr, reg_wdata, host_addr} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        set(8'h23, 8'hC0);
        wr(2'h2, 8'h01);
        get(8'h23, d);
        check("write outside cfg", d, 8'h00);
        for (i = 0; i < 6; i++) begin
            get(8'h22 + i[7:0], d);
            check("reset value", d, 8'h00);
        end
        for (i = 0; i < 6; i++) begin
            e8 = (i == 0) ? 8'h3F : (i == 2 || i == 3) ? 8'hFE : 8'hFF;
            set(8'h22 + i[7:0], 8'hFF);
            get(8'h22 + i[7:0], d);
            check("read back", d, e8);
        end
        set(8'h28, 8'h5A);
        get(8'h28, d);
        check("unknown index", d, 8'h00);
        rd(2'h3, d);
        check("unmapped offset", d, 8'h00);
        $display("register tests done");
        set(8'h23, 8'hDE);
        set(8'h24, 8'hF0);
        set(8'h25, 8'h40);
        hit(16'h037A);
        check("par hit", {par_sel, ser1_sel, ser2_sel}, 3'b100);
        hit(16'h037C);
        check("par miss", par_sel, 1'b0);
        hit(16'h077A);
        check("par a10", par_sel, 1'b0);
        hit(16'h03C7);
        check("ser1 hit", {par_sel, ser1_sel}, 2'b01);
        hit(16'h43C7);
        check("ser1 high", ser1_sel, 1'b0);
        hit(16'h0105);
        check("ser2 hit", ser2_sel, 1'b1);
        hit(16'h0505);
        check("ser2 a10", ser2_sel, 1'b0);
        wr(2'h2, 8'h03);
        hit(16'h037C);
        check("epp hit", par_sel, 1'b1);
        wr(2'h2, 8'h05);
        hit(16'h077A);
        check("ecp upper", par_upper_sel, 1'b1);
        wr(2'h2, 8'h01);
        set(8'h23, 8'h3E);
        set(8'h25, 8'h3E);
        hit(16'h00F8);
        check("disabled", {par_sel, ser2_sel}, 2'b00);
        $display("decode tests done");
        par_dma_req <= 1'b1;
        par_irq <= 1'b1;
        for (i = 0; i < 16; i++) begin
            set(8'h26, {4'h0, i[3:0]});
            set(8'h27, {4'h0, i[3:0]});
            hit(16'h0000);
            e3 = (i >= 1 && i <= 3) ? 3'b001 << (i - 1) : 3'b000;
            e15 = (i == 0) ? 15'h0000 : 15'h0001 << (i - 1);
            check("dma oe", dma_request_oe, e3);
            check("dma out", dma_request_out, e3);
            check("irq oe", irq_oe, e15);
            check("irq out", irq_out, e15);
        end
        set(8'h26, 8'h02);
        set(8'h22, 8'h3F);
        par_irq <= 1'b0;
        par_dma_req <= 1'b0;
        hit(16'h0000);
        check("dma after ind", dma_request_oe, 3'b010);
        check("dma low", dma_request_out, 3'b000);
        check("irq low", irq_out, 15'h0000);
        $display("routing tests done");
        complete_run();
    end
endmodule : legacy_port_resource_map_tb
`default_nettype wire
